/* core/afm_pkg.sv */
package afm_pkg;

    // serial word layout: first received bit ends up at the top of the word
    localparam int unsigned AFM_WORD_W      = 8;
    localparam int unsigned AFM_ATT_W       = 7;
    localparam int unsigned AFM_FLAG_W      = 6;
    localparam int unsigned AFM_SEL_POS     = 7;
    localparam int unsigned AFM_GRP_POS     = 6;
    localparam int unsigned AFM_ATT_MSB     = 6;
    localparam int unsigned AFM_FLAG_MSB    = 5;

    // reset values of the stored words
    localparam logic [6:0]  AFM_ATT_RST     = 7'h00;
    localparam logic [5:0]  AFM_FLAG_RST    = 6'h00;
    localparam logic [7:0]  AFM_WORD_RST    = 8'h00;

    // selector values
    localparam logic        AFM_SEL_ATT     = 1'b0;
    localparam logic        AFM_GRP_ONE     = 1'b0;

    // synchroniser depth for every pin input
    localparam int unsigned AFM_SYNC_STAGES = 2;

    // group 1, first field is the first flag received (bit 5)
    typedef struct packed {
        logic both_outputs_left;
        logic both_outputs_right;
        logic cd_rate_flag;
        logic rate_choice_flag;
        logic emphasis_undo_flag;
        logic silence_flag;
    } afm_group1_t;

    // group 2, same ordering
    typedef struct packed {
        logic system_clock_choice;
        logic word_clock_polarity;
        logic input_length_select;
        logic output_short_select;
        logic output_long_select;
        logic dc_shift_enable;
    } afm_group2_t;

    // control pins that are ored with interface flags
    typedef struct packed {
        logic cd_rate_pin;
        logic rate_choice_pin;
        logic emphasis_undo_pin;
        logic silence_pin;
    } afm_pins_t;

    // effective settings after the or
    typedef struct packed {
        logic cd_rate_effective;
        logic rate_choice_effective;
        logic emphasis_undo_effective;
        logic silence_effective;
    } afm_effective_t;

    typedef enum logic [1:0] {
        AFM_BIL_STEREO  = 2'h0,
        AFM_BIL_RIGHT   = 2'h1,
        AFM_BIL_INVALID = 2'h3,
        AFM_BIL_LEFT    = 2'h2
    } afm_bilingual_t;

    typedef enum logic [1:0] {
        AFM_OUT_16 = 2'h0,
        AFM_OUT_18 = 2'h1,
        AFM_OUT_20 = 2'h2
    } afm_out_len_t;

    // waiting for the first word clock edge after reset, then running
    typedef enum logic {
        AFM_ST_WAIT_WCLK = 1'b0,
        AFM_ST_RUN       = 1'b1
    } afm_state_t;

endpackage

/* core/afm_sync.sv */
module afm_sync
    import afm_pkg::*;
#(
    parameter int unsigned W = 4
) (
    input  wire logic         core_clk,
    input  wire logic         arst_n,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);

    logic [W-1:0] meta_q;

    // two stages; the first one is read by the second only
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            meta_q   <= '0;
            sync_out <= '0;
        end else begin
            meta_q   <= async_in;
            sync_out <= meta_q;
        end
    end

endmodule

/* core/afm_shift.sv */
module afm_shift
    import afm_pkg::*;
#(
    parameter int unsigned W = AFM_WORD_W
) (
    input  wire logic         core_clk,
    input  wire logic         arst_n,
    input  wire logic         shift_en,
    input  wire logic         bit_in,
    output logic      [W-1:0] word_q
);

    // oldest bit moves toward the msb; extra pulses just push it out
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            word_q <= '0;
        end else if (shift_en) begin
            word_q <= {word_q[W-2:0], bit_in};
        end
    end

endmodule

/* core/afm_mode_ctrl.sv */
module afm_mode_ctrl
    import afm_pkg::*;
(
    input  wire logic           core_clk,
    input  wire logic           arst_n,
    input  wire logic           serial_config_data,
    input  wire logic           serial_config_clock,
    input  wire logic           config_latch_strobe,
    input  wire logic           word_clock_in,
    input  wire afm_pins_t      control_pins,
    output logic [6:0]          attenuation_coefficient,
    output afm_group1_t         mode_group_one,
    output afm_group2_t         mode_group_two,
    output afm_effective_t      effective,
    output logic                cd_mode_active,
    output logic                emphasis_active,
    output logic                soft_mute_active,
    output afm_bilingual_t      bilingual_mode,
    output logic                half_rate_sys_clock,
    output logic                left_while_wclk_high,
    output logic                input_18bit,
    output afm_out_len_t        output_length,
    output logic                dc_offset_active,
    output logic                config_ready
);

    logic [3:0]              link_s;
    afm_pins_t               pins_s;
    logic                    sclk_prev_q;
    logic                    strobe_prev_q;
    logic                    wclk_prev_q;
    logic [2:0]              settle_q;
    logic                    sclk_rise;
    logic                    strobe_rise;
    logic                    wclk_rise;
    logic                    data_s;
    logic [AFM_WORD_W-1:0]   shift_word;
    afm_state_t              state_q;
    afm_state_t              state_d;
    logic                    init_clear;
    logic                    store_att;
    logic                    store_one;
    logic                    store_two;
    logic [6:0]              att_q;
    afm_group1_t             grp1_q;
    afm_group2_t             grp2_q;
    afm_effective_t          eff_d;

    // link pins share one synchroniser so their relative timing is kept
    afm_sync #(
        .W        (4)
    ) u_link_sync (
        .core_clk (core_clk),
        .arst_n   (arst_n),
        .async_in ({serial_config_data, serial_config_clock,
                    config_latch_strobe, word_clock_in}),
        .sync_out (link_s)
    );

    // static control pins are asynchronous too
    afm_sync #(
        .W        (4)
    ) u_pin_sync (
        .core_clk (core_clk),
        .arst_n   (arst_n),
        .async_in (control_pins),
        .sync_out (pins_s)
    );

    assign data_s = link_s[3];

    // previous samples for edge detection, taken after the sync stages
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            sclk_prev_q   <= 1'b0;
            strobe_prev_q <= 1'b0;
            wclk_prev_q   <= 1'b0;
            settle_q      <= 3'h0;
        end else begin
            sclk_prev_q   <= link_s[2];
            strobe_prev_q <= link_s[1];
            wclk_prev_q   <= link_s[0];
            settle_q      <= {settle_q[1:0], 1'b1}; // idle-high strobe no edge
        end
    end

    assign sclk_rise   = link_s[2] & ~sclk_prev_q & settle_q[2];
    assign strobe_rise = link_s[1] & ~strobe_prev_q & settle_q[2];
    assign wclk_rise   = link_s[0] & ~wclk_prev_q & settle_q[2];

    // data is delayed by the same stages as the clock, so the bit seen at
    // the detected edge is the one the host held stable around it
    afm_shift #(
        .W        (AFM_WORD_W)
    ) u_shift (
        .core_clk (core_clk),
        .arst_n   (arst_n),
        .shift_en (sclk_rise),
        .bit_in   (data_s),
        .word_q   (shift_word)
    );

    // reset-release sequencer: waits for the first word clock rise
    always_comb begin
        state_d = state_q;
        case (state_q)
            AFM_ST_WAIT_WCLK: begin
                if (wclk_rise) begin
                    state_d = AFM_ST_RUN;
                end
            end
            AFM_ST_RUN: begin
                state_d = AFM_ST_RUN;
            end
            default: begin
                state_d = AFM_ST_WAIT_WCLK;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_q <= AFM_ST_WAIT_WCLK;
        end else begin
            state_q <= state_d;
        end
    end

    assign init_clear = (state_q == AFM_ST_WAIT_WCLK) && wclk_rise;

    // selector decode on the latch edge
    assign store_att = strobe_rise
                     && (shift_word[AFM_SEL_POS] == AFM_SEL_ATT);
    assign store_one = strobe_rise
                     && (shift_word[AFM_SEL_POS] != AFM_SEL_ATT)
                     && (shift_word[AFM_GRP_POS] == AFM_GRP_ONE);
    assign store_two = strobe_rise
                     && (shift_word[AFM_SEL_POS] != AFM_SEL_ATT)
                     && (shift_word[AFM_GRP_POS] != AFM_GRP_ONE);

    // attenuation word; the clear on the first word clock edge wins
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            att_q <= AFM_ATT_RST;
        end else if (init_clear) begin
            att_q <= AFM_ATT_RST;
        end else if (store_att) begin
            att_q <= shift_word[AFM_ATT_MSB:0];
        end
    end

    // group 1 flags
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            grp1_q <= afm_group1_t'(AFM_FLAG_RST);
        end else if (init_clear) begin
            grp1_q <= afm_group1_t'(AFM_FLAG_RST);
        end else if (store_one) begin
            grp1_q <= afm_group1_t'(shift_word[AFM_FLAG_MSB:0]);
        end
    end

    // group 2 flags
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            grp2_q <= afm_group2_t'(AFM_FLAG_RST);
        end else if (init_clear) begin
            grp2_q <= afm_group2_t'(AFM_FLAG_RST);
        end else if (store_two) begin
            grp2_q <= afm_group2_t'(shift_word[AFM_FLAG_MSB:0]);
        end
    end

    // pins alone rule while flags stay low; system must tie pins low
    // when it drives settings over the serial link
    always_comb begin
        eff_d.cd_rate_effective       = pins_s.cd_rate_pin
                                      | grp1_q.cd_rate_flag;
        eff_d.rate_choice_effective   = pins_s.rate_choice_pin
                                      | grp1_q.rate_choice_flag;
        eff_d.emphasis_undo_effective = pins_s.emphasis_undo_pin
                                      | grp1_q.emphasis_undo_flag;
        eff_d.silence_effective       = pins_s.silence_pin
                                      | grp1_q.silence_flag;
    end

    // effective settings and their plain meanings, all registered
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            effective        <= '0;
            cd_mode_active   <= 1'b0;
            emphasis_active  <= 1'b0;
            soft_mute_active <= 1'b0;
        end else begin
            effective        <= eff_d;
            cd_mode_active   <= eff_d.cd_rate_effective;
            emphasis_active  <= eff_d.emphasis_undo_effective;
            soft_mute_active <= eff_d.silence_effective;
        end
    end

    // bilingual decode; both flags high is passed on as invalid
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            bilingual_mode <= AFM_BIL_STEREO;
        end else begin
            case ({grp1_q.both_outputs_left, grp1_q.both_outputs_right})
                2'h0:    bilingual_mode <= AFM_BIL_STEREO;
                2'h1:    bilingual_mode <= AFM_BIL_RIGHT;
                2'h2:    bilingual_mode <= AFM_BIL_LEFT;
                default: bilingual_mode <= AFM_BIL_INVALID;
            endcase
        end
    end

    // group 2 meanings
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            half_rate_sys_clock  <= 1'b0;
            left_while_wclk_high <= 1'b1;
            input_18bit          <= 1'b0;
            dc_offset_active     <= 1'b0;
        end else begin
            half_rate_sys_clock  <= grp2_q.system_clock_choice;
            left_while_wclk_high <= ~grp2_q.word_clock_polarity;
            input_18bit          <= grp2_q.input_length_select;
            dc_offset_active     <= grp2_q.dc_shift_enable;
        end
    end

    // output length; both selects high falls back to 18 bits
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            output_length <= AFM_OUT_18;
        end else begin
            case ({grp2_q.output_short_select, grp2_q.output_long_select})
                2'h1:    output_length <= AFM_OUT_20;
                2'h2:    output_length <= AFM_OUT_16;
                default: output_length <= AFM_OUT_18;
            endcase
        end
    end

    // high once the post-reset clear has happened
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            config_ready <= 1'b0;
        end else begin
            config_ready <= (state_d == AFM_ST_RUN);
        end
    end

    assign attenuation_coefficient = att_q;
    assign mode_group_one          = grp1_q;
    assign mode_group_two          = grp2_q;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);

    sequence s_latch_att;
        strobe_rise && !init_clear && !shift_word[AFM_SEL_POS];
    endsequence

    sequence s_latch_grp(logic g);
        strobe_rise && !init_clear && shift_word[AFM_SEL_POS]
            && (shift_word[AFM_GRP_POS] == g);
    endsequence

    a_shift_takes_bit: assert property (
        sclk_rise |=> shift_word == {$past(shift_word[6:0]), $past(data_s)})
        else $error("shift word did not take the serial bit");

    a_att_stored: assert property (
        s_latch_att |=> att_q == $past(shift_word[6:0])
            ##1 (att_q == $past(shift_word[6:0], 2) || $past(init_clear)))
        else $error("attenuation not stored from word");

    a_grp_one_stored: assert property (
        s_latch_grp(1'b0) |=> grp1_q == $past(shift_word[5:0])
            && $stable(grp2_q) && $stable(att_q))
        else $error("group one store wrong");

    a_grp_two_stored: assert property (
        s_latch_grp(1'b1) |=> grp2_q == $past(shift_word[5:0])
            && $stable(grp1_q) && $stable(att_q))
        else $error("group two store wrong");

    a_regs_hold: assert property (
        !strobe_rise && !init_clear
            |=> $stable(att_q) && $stable(grp1_q) && $stable(grp2_q))
        else $error("stored word changed without a latch edge");

    a_effective_or: assert property (
        ##1 $changed(grp1_q) || effective == ($past(pins_s) | grp1_q[3:0]))
        else $error("effective setting is not pin or flag");

    a_mute_follows: assert property (
        ##1 soft_mute_active == $past(eff_d.silence_effective))
        else $error("soft mute not active with effective mute high");

    a_bil_invalid: assert property (
        (grp1_q.both_outputs_left && grp1_q.both_outputs_right) [*2]
            |-> bilingual_mode == AFM_BIL_INVALID)
        else $error("both bilingual flags not reported invalid");

    a_out_len_decode: assert property (
        $stable(grp2_q) && !grp2_q.output_short_select
            && grp2_q.output_long_select |=> output_length == AFM_OUT_20)
        else $error("output length decode wrong");

    a_init_clear: assert property (
        init_clear |=> att_q == AFM_ATT_RST && grp1_q == '0 && grp2_q == '0
            && state_q == AFM_ST_RUN ##1 config_ready)
        else $error("first word clock edge did not clear settings");

endmodule

/* tb/afm_host_model.sv */
// host side of the three-wire mode link, driven from the bench clock
module afm_host_model (
    input  wire logic core_clk,
    output logic      serial_config_data,
    output logic      serial_config_clock,
    output logic      config_latch_strobe
);
    timeunit 1ns;
    timeprecision 1ps;

    // link idles with the clock parked low and the strobe high
    initial begin
        serial_config_data  = 1'h0;
        serial_config_clock = 1'h0;
        config_latch_strobe = 1'h1;
    end

    // sends n bits, bits[n-1] first; 80 ns link period = 8 core cycles
    task automatic send_word(input logic [15:0] bits, input int n);
        @(posedge core_clk);
        config_latch_strobe <= 1'h0;
        for (int i = n - 1; i >= 0; i--) begin
            @(posedge core_clk);
            serial_config_clock <= 1'h0;
            serial_config_data  <= bits[i];
            repeat (4) @(posedge core_clk);
            serial_config_clock <= 1'h1;
            repeat (3) @(posedge core_clk);
        end
        // hold time over: data no longer shows the last bit
        @(posedge core_clk);
        serial_config_clock <= 1'h0;
        serial_config_data  <= ~serial_config_data;
        // strobe rises 80 ns after the last clock rise, well past setup
        repeat (4) @(posedge core_clk);
        config_latch_strobe <= 1'h1;
        // stored word and decodes settle within a handful of edges
        repeat (10) @(posedge core_clk);
    endtask
endmodule

/* tb/audio_filter_mode_control_tb_top.sv */
module audio_filter_mode_control_tb_top
    import afm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic           core_clk;
    logic           arst_n;
    logic           sdata;
    logic           sclk;
    logic           slatch;
    logic           wclk;
    afm_pins_t      pins;
    logic [6:0]     att;
    afm_group1_t    g1;
    afm_group2_t    g2;
    afm_effective_t eff;
    logic           cd_act;
    logic           emph_act;
    logic           mute_act;
    afm_bilingual_t bil;
    logic           half_clk;
    logic           left_hi;
    logic           in18;
    afm_out_len_t   out_len;
    logic           dc_act;
    logic           ready;
    logic [6:0]     att_e;
    afm_group1_t    g1_e;
    afm_group2_t    g2_e;
    int             num_errors;
    int             total_checks;

    afm_host_model u_host (
        .core_clk            (core_clk),
        .serial_config_data  (sdata),
        .serial_config_clock (sclk),
        .config_latch_strobe (slatch)
    );

    afm_mode_ctrl u_dut (
        .core_clk                (core_clk),
        .arst_n                  (arst_n),
        .serial_config_data      (sdata),
        .serial_config_clock     (sclk),
        .config_latch_strobe     (slatch),
        .word_clock_in           (wclk),
        .control_pins            (pins),
        .attenuation_coefficient (att),
        .mode_group_one          (g1),
        .mode_group_two          (g2),
        .effective               (eff),
        .cd_mode_active          (cd_act),
        .emphasis_active         (emph_act),
        .soft_mute_active        (mute_act),
        .bilingual_mode          (bil),
        .half_rate_sys_clock     (half_clk),
        .left_while_wclk_high    (left_hi),
        .input_18bit             (in18),
        .output_length           (out_len),
        .dc_offset_active        (dc_act),
        .config_ready            (ready)
    );

    // 100 MHz core clock
    always #5 core_clk = ~core_clk;

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one place that ends the run, also reached by the watchdog
    task automatic give_verdict();
        $display("checks=%0d errors=%0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // comparison of every output except ready: expectations rebuilt from flags and pins
    task automatic check_all();
        logic [3:0]     e;
        afm_bilingual_t be;
        afm_out_len_t   oe;
        // look between edges so every launched output has settled
        @(negedge core_clk);
        e = pins | {g1_e.cd_rate_flag, g1_e.rate_choice_flag,
                    g1_e.emphasis_undo_flag, g1_e.silence_flag};
        be = (g1_e.both_outputs_left && g1_e.both_outputs_right) ?
             AFM_BIL_INVALID : g1_e.both_outputs_left ? AFM_BIL_LEFT :
             g1_e.both_outputs_right ? AFM_BIL_RIGHT : AFM_BIL_STEREO;
        oe = (g2_e.output_short_select ^ g2_e.output_long_select) ?
             (g2_e.output_short_select ? AFM_OUT_16 : AFM_OUT_20) :
             AFM_OUT_18;
        chk({1'h0, att}, {1'h0, att_e});
        chk({2'h0, g1}, {2'h0, g1_e});
        chk({2'h0, g2}, {2'h0, g2_e});
        chk({4'h0, eff}, {4'h0, e});
        chk({7'h00, cd_act}, {7'h00, e[3]});
        chk({7'h00, emph_act}, {7'h00, e[1]});
        chk({7'h00, mute_act}, {7'h00, e[0]});
        chk({6'h00, bil}, {6'h00, be});
        chk({6'h00, out_len}, {6'h00, oe});
        chk({7'h00, half_clk}, {7'h00, g2_e.system_clock_choice});
        chk({7'h00, left_hi}, {7'h00, ~g2_e.word_clock_polarity});
        chk({7'h00, in18}, {7'h00, g2_e.input_length_select});
        chk({7'h00, dc_act}, {7'h00, g2_e.dc_shift_enable});
    endtask

    task automatic wr(input logic [7:0] w);
        u_host.send_word({8'h00, w}, 8);
    endtask

    // nothing written yet: every flag low, pins alone decide
    task automatic t_defaults();
        check_all();
        chk({7'h00, ready}, 8'h00);
    endtask

    // a word stored before the first word clock rise is wiped by it
    task automatic t_first_wclk();
        wr(8'h2A);
        att_e = 7'h2A;
        check_all();
        @(posedge core_clk);
        wclk <= 1'h1;
        repeat (8) @(posedge core_clk);
        wclk <= 1'h0;
        att_e = 7'h00;
        check_all();
        chk({7'h00, ready}, 8'h01);
        // later word clock rises must leave stored words alone
        wr(8'h15);
        att_e = 7'h15;
        @(posedge core_clk);
        wclk <= 1'h1;
        repeat (8) @(posedge core_clk);
        wclk <= 1'h0;
        check_all();
    endtask

    // attenuation boundaries, first bit zero selects the coefficient
    task automatic t_atten();
        logic [6:0] vals [4];
        vals = '{7'h7F, 7'h00, 7'h01, 7'h40};
        foreach (vals[i]) begin
            wr({1'h0, vals[i]});
            att_e = vals[i];
            check_all();
        end
    endtask

    // each flag alone, all flags, none, in both groups
    task automatic t_groups();
        logic [5:0] v;
        for (int g = 0; g < 2; g++) begin
            for (int k = 0; k < 8; k++) begin
                v = (k < 6) ? (6'h01 << k) : ((k == 6) ? 6'h3F : 6'h00);
                if (g == 0)
                    g1_e = v;
                else
                    g2_e = v;
                wr({1'h1, g[0], v});
                check_all();
            end
        end
    endtask

    // pins ored with flags; pins go high on purpose here
    task automatic t_pins();
        for (int k = 0; k < 5; k++) begin
            @(posedge core_clk);
            pins <= (k < 4) ? (4'h1 << k) : 4'h0;
            repeat (6) @(posedge core_clk);
            check_all();
        end
        wr(8'h8A);
        g1_e = 6'h0A;
        @(posedge core_clk);
        pins <= 4'h5;
        repeat (6) @(posedge core_clk);
        check_all();
        @(posedge core_clk);
        pins <= 4'h0;
        repeat (6) @(posedge core_clk);
        check_all();
    endtask

    // extra and missing clock pulses just slide the 8-bit window
    task automatic t_window();
        u_host.send_word({5'h00, 3'h7, 8'h33}, 11);
        att_e = 7'h33;
        check_all();
        u_host.send_word(16'h000A, 4);
        att_e = 7'h3A;
        check_all();
    endtask

    // reset in mid-run wipes stored words; the next word clock rise
    // clears once more and raises ready again
    task automatic t_reset();
        wr(8'hBF);
        g1_e = 6'h3F;
        check_all();
        @(posedge core_clk);
        arst_n <= 1'h0;
        repeat (2) @(posedge core_clk);
        arst_n <= 1'h1;
        att_e = 7'h00;
        g1_e  = 6'h00;
        g2_e  = 6'h00;
        repeat (4) @(posedge core_clk);
        check_all();
        chk({7'h00, ready}, 8'h00);
        @(posedge core_clk);
        wclk <= 1'h1;
        repeat (8) @(posedge core_clk);
        wclk <= 1'h0;
        check_all();
        chk({7'h00, ready}, 8'h01);
    endtask

    // watchdog: whole run needs well under 200 us
    initial begin
        #200000;
        num_errors++;
        give_verdict();
    end

    initial begin
        core_clk     = 1'h0;
        arst_n       = 1'h0;
        wclk         = 1'h0;
        pins         = 4'h0;
        att_e        = 7'h00;
        g1_e         = 6'h00;
        g2_e         = 6'h00;
        num_errors   = 0;
        total_checks = 0;
        repeat (2) @(posedge core_clk);
        arst_n <= 1'h1;
        repeat (4) @(posedge core_clk);
        t_defaults();
        t_first_wclk();
        t_atten();
        t_groups();
        t_pins();
        t_window();
        t_reset();
        give_verdict();
    end
endmodule
